// ---- src/brc_brownout_reset_control.sv ----
// Reset sequencer with brown-out supervision and APB control registers
//
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "brc_defines.svh"

module brc_brownout_reset_control #(
  parameter int              POWER_UP_TIMER_CYCLES = `BRC_POWER_UP_TIMER_MS * `BRC_NS_PER_MS / `BRC_CLK_PERIOD_NS,
  parameter logic [`BRC_ID_W-1:0] PART_ID     = `BRC_PART_ID_DEFAULT,
  parameter logic [`BRC_ID_W-1:0] REV_ID      = `BRC_REV_ID_DEFAULT
) (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [`BRC_ADDR_W-1:0] paddr,
  input  wire logic [31:0]            pwdata,
  input  wire logic [3:0]             pstrb,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire brc_pkg::brc_async_s    analog_in,
  input  wire brc_pkg::brc_cfg_s      cfg,
  input  wire brc_pkg::brc_evt_s      core_evt,
  output logic                        device_reset,
  output logic                        exec_hold,
  output logic                        brown_out_detector_on,
  output logic                        bandgap_force_on
);
  import brc_pkg::*;

  // Filter length: a least time, so round up to whole cycles
  localparam int FILT_CYCLES =
    (`BRC_BOR_FILTER_NS + `BRC_CLK_PERIOD_NS - 1) / `BRC_CLK_PERIOD_NS;
  localparam logic [`BRC_FILT_W-1:0] FILT_LAST = `BRC_FILT_W'(FILT_CYCLES - 1);
  localparam logic [`BRC_POWER_UP_TIMER_W-1:0] POWER_UP_TIMER_LAST = `BRC_POWER_UP_TIMER_W'(POWER_UP_TIMER_CYCLES - 1);

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  brc_async_s meta_reg;
  brc_async_s sync_reg;

  // Reset clears both stages: presetn itself stands for power-on, so the
  // two edges before a low supply is seen cost nothing
  // Stage one feeds stage two only; everything else reads sync_reg
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_reg <= '0;
      sync_reg <= '0;
    end
    else
    begin
      meta_reg <= analog_in;
      sync_reg <= meta_reg;
    end
  end

  // ****************************************************************
  // Detector mode decode
  // ****************************************************************
  logic       soft_en_reg;
  logic       fast_start_reg;
  logic [1:0] mode;
  logic       det_active;
  logic       below_trip;
  logic       wait_ready;
  logic       ready_seen;

  assign mode = cfg.brown_out_mode_field;

  // Detector power follows mode; software mode ignores sleep
  always_comb
  begin
    unique case (mode)
      `BRC_MODE_ALWAYS_ON:  det_active = 1'b1;
      `BRC_MODE_OFF_SLEEP:  det_active = ~core_evt.sleep;
      `BRC_MODE_SOFTWARE:   det_active = soft_en_reg;
      `BRC_MODE_ALWAYS_OFF: det_active = 1'b0;
    endcase
  end

  // Trip select one picks the low threshold comparator
  assign below_trip = cfg.brown_out_trip_select ? sync_reg.below_trip_low
                                                : sync_reg.below_trip_high;
  // Only always-on and off-in-sleep modes gate start-up on readiness
  assign wait_ready = (mode == `BRC_MODE_ALWAYS_ON) | (mode == `BRC_MODE_OFF_SLEEP);
  // Protection starts only once the detector reports ready
  assign ready_seen = det_active & sync_reg.det_ready;

  // ****************************************************************
  // Brown-out noise filter
  // ****************************************************************
  logic [`BRC_FILT_W-1:0] filt_cnt_reg;
  logic                   bor_main_reg;
  logic                   bor_any;
  logic                   por_event;

  // The counter parks at its last value, so a long dip keeps the request
  // standing without wrapping back to zero
  // Dips shorter than the filter time never reach the reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      filt_cnt_reg <= '0;
      bor_main_reg <= 1'b0;
    end
    else if (!(ready_seen && below_trip))
    begin
      filt_cnt_reg <= '0;
      bor_main_reg <= 1'b0;
    end
    else if (filt_cnt_reg == FILT_LAST)
    begin
      bor_main_reg <= 1'b1;
    end
    else
    begin
      filt_cnt_reg <= filt_cnt_reg + 1'b1;
    end
  end

  // Low-power detector joins the main one into one brown-out request
  assign bor_any   = bor_main_reg |
                     (sync_reg.lp_bor_req & ~cfg.low_power_brown_out_enable_n);
  // Leaving programming mode behaves as a fresh power-on
  assign por_event = sync_reg.por_low | core_evt.prog_exit;

  // ****************************************************************
  // Start-up sequencer
  // ****************************************************************
  brc_state_e             state_reg;
  brc_state_e             state_next;
  logic [`BRC_POWER_UP_TIMER_W-1:0] power_up_timer_cnt_reg;
  logic                   supply_ok;

  assign supply_ok = sync_reg.det_ready & ~below_trip;

  // A brown-out in the middle of the timer restarts it from zero; repeated
  // dips cost time but can never shorten the delay
  // Any power-on or brown-out sends the sequence back to the start
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      BRC_ST_HOLD:
      begin
        if (!(por_event || bor_any))
        begin
          state_next = cfg.power_up_timer_enable_n ? BRC_ST_READY
                                                   : BRC_ST_POWER_UP_TIMER;
        end
      end
      BRC_ST_POWER_UP_TIMER:
      begin
        if (por_event || bor_any)
        begin
          state_next = BRC_ST_HOLD;
        end
        else if (power_up_timer_cnt_reg == POWER_UP_TIMER_LAST)
        begin
          state_next = BRC_ST_READY;
        end
      end
      BRC_ST_READY:
      begin
        if (por_event || bor_any)
        begin
          state_next = BRC_ST_HOLD;
        end
        else if (!wait_ready || supply_ok)
        begin
          state_next = BRC_ST_RUN;
        end
      end
      BRC_ST_RUN:
      begin
        if (por_event || bor_any)
        begin
          state_next = BRC_ST_HOLD;
        end
      end
      default: state_next = BRC_ST_HOLD;
    endcase
  end

  // State register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= BRC_ST_HOLD;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // Timer counts only in its own state, so it restarts from zero every time
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      power_up_timer_cnt_reg <= '0;
    end
    else if (state_reg == BRC_ST_POWER_UP_TIMER)
    begin
      power_up_timer_cnt_reg <= power_up_timer_cnt_reg + 1'b1;
    end
    else
    begin
      power_up_timer_cnt_reg <= '0;
    end
  end

  // ****************************************************************
  // Reset and control outputs
  // ****************************************************************
  logic pin_reset;
  logic core_reset;

  assign pin_reset  = cfg.external_reset_enable & ~sync_reg.ext_pin_n;
  assign core_reset = core_evt.watchdog | core_evt.reset_instr |
                      (cfg.stack_reset_enable & (core_evt.stack_ovf | core_evt.stack_unf));

  // Reading state_next lets the release come one edge after RUN is chosen
  // Core sources give a one-cycle reset; they do not restart the sequence
  // All sources merge here; start-up delays keep it high until RUN
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      device_reset <= 1'b1;
    end
    else
    begin
      device_reset <= (state_next != BRC_ST_RUN) | por_event | bor_any |
                      pin_reset | core_reset;
    end
  end

  // Limitation: the hold only stalls the core, the reset itself stays low
  // Wake-up in off-in-sleep mode waits for the detector to come back
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      exec_hold <= 1'b0;
    end
    else
    begin
      exec_hold <= (mode == `BRC_MODE_OFF_SLEEP) & ~core_evt.sleep &
                   ~sync_reg.det_ready & (state_reg == BRC_ST_RUN);
    end
  end

  // Analog enables; fast start only matters where the detector can sleep
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      brown_out_detector_on <= 1'b0;
      bandgap_force_on      <= 1'b0;
    end
    else
    begin
      brown_out_detector_on <= det_active;
      bandgap_force_on      <= fast_start_reg &
                               ((mode == `BRC_MODE_OFF_SLEEP) | (mode == `BRC_MODE_SOFTWARE));
    end
  end

  // ****************************************************************
  // APB slave
  // ****************************************************************
  logic acc;
  logic hit_ctrl;
  logic hit_part;
  logic hit_rev;

  assign acc      = psel & penable & pready;
  assign hit_ctrl = (paddr == `BRC_ADDR_CTRL);
  assign hit_part = (paddr == `BRC_ADDR_PART);
  assign hit_rev  = (paddr == `BRC_ADDR_REV);

  // A write in the same cycle as a restore is lost: the restore wins
  // Control bits survive every reset except power-on and brown-out
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      soft_en_reg    <= `BRC_RST_SOFT_EN;
      fast_start_reg <= `BRC_RST_FAST_START;
    end
    else if (por_event || bor_any)
    begin
      soft_en_reg    <= `BRC_RST_SOFT_EN;
      fast_start_reg <= `BRC_RST_FAST_START;
    end
    else if (acc && pwrite && hit_ctrl && pstrb[0])
    begin
      soft_en_reg    <= pwdata[`BRC_BIT_SOFT_EN];
      fast_start_reg <= pwdata[`BRC_BIT_FAST_START];
    end
  end

  // Read data is taken at the setup edge, so it shows state one cycle old
  // Zero wait states: answer in the first access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end
    else
    begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~(hit_ctrl | hit_part | hit_rev) |
                 psel & ~penable & pwrite & (hit_part | hit_rev);
      prdata  <= '0;
      if (psel && !penable && !pwrite)
      begin
        if (hit_ctrl)
        begin
          prdata[`BRC_BIT_SOFT_EN]    <= soft_en_reg;
          prdata[`BRC_BIT_FAST_START] <= fast_start_reg;
          prdata[`BRC_BIT_READY]      <= ready_seen;
        end
        else if (hit_part)
        begin
          prdata[`BRC_ID_W-1:0] <= PART_ID;
        end
        else if (hit_rev)
        begin
          prdata[`BRC_ID_W-1:0] <= REV_ID;
        end
      end
    end
  end

endmodule : brc_brownout_reset_control
`default_nettype wire

// ---- src/brc_defines.svh ----
// Constants for the brown-out reset controller: offsets, fields, resets, timing
`ifndef BRC_DEFINES_SVH
`define BRC_DEFINES_SVH

// ****************************************************************
// Register map (byte addresses on the APB port)
// ****************************************************************
`define BRC_ADDR_W            12
`define BRC_ADDR_CTRL         12'h000
`define BRC_ADDR_PART         12'h004
`define BRC_ADDR_REV          12'h008

// ****************************************************************
// Control register fields and reset values
// ****************************************************************
`define BRC_BIT_SOFT_EN       7
`define BRC_BIT_FAST_START    6
`define BRC_BIT_READY         0
`define BRC_RST_SOFT_EN       1'h1
`define BRC_RST_FAST_START    1'h0
`define BRC_ID_W              14
// Arbitrary neutral identity values
`define BRC_PART_ID_DEFAULT   14'h0123
`define BRC_REV_ID_DEFAULT    14'h0001

// ****************************************************************
// Brown-out mode field encodings
// ****************************************************************
`define BRC_MODE_ALWAYS_ON    2'h3
`define BRC_MODE_OFF_SLEEP    2'h2
`define BRC_MODE_SOFTWARE     2'h1
`define BRC_MODE_ALWAYS_OFF   2'h0

// ****************************************************************
// Timing
// ****************************************************************
`define BRC_CLK_PERIOD_NS     5
`define BRC_POWER_UP_TIMER_MS           64
`define BRC_NS_PER_MS         1000000
`define BRC_BOR_FILTER_NS     100
`define BRC_POWER_UP_TIMER_W            24
`define BRC_FILT_W            8

`endif

// ---- src/brc_pkg.sv ----
// Types shared by the brown-out reset controller and its bench
package brc_pkg;

  // ****************************************************************
  // Inputs from outside the clock domain, synchronised on entry
  // ****************************************************************
  typedef struct packed {
    logic por_low;           // Supply below minimum operating level
    logic below_trip_high;   // Supply below high brown-out trip voltage
    logic below_trip_low;    // Supply below low brown-out trip voltage
    logic lp_bor_req;        // Low-power brown-out detector request
    logic det_ready;         // Brown-out detector ready
    logic ext_pin_n;         // External reset pin level, low resets
  } brc_async_s;

  // ****************************************************************
  // Static configuration word bits
  // ****************************************************************
  typedef struct packed {
    logic [1:0] brown_out_mode_field;
    logic       power_up_timer_enable_n;
    logic       brown_out_trip_select;
    logic       low_power_brown_out_enable_n;
    logic       external_reset_enable;
    logic       stack_reset_enable;
  } brc_cfg_s;

  // ****************************************************************
  // Same-clock requests from core logic
  // ****************************************************************
  typedef struct packed {
    logic watchdog;
    logic reset_instr;
    logic stack_ovf;
    logic stack_unf;
    logic prog_exit;
    logic sleep;
  } brc_evt_s;

  typedef enum logic [3:0] {
    BRC_ST_HOLD  = 4'b0001,
    BRC_ST_POWER_UP_TIMER  = 4'b0010,
    BRC_ST_READY = 4'b0100,
    BRC_ST_RUN   = 4'b1000
  } brc_state_e;

endpackage : brc_pkg

// ---- tb/brc_brownout_reset_control_tb_top.sv ----
// Self-checking bench for the brown-out reset controller
`timescale 1ns/100ps
`default_nettype none
`include "brc_defines.svh"
module brc_brownout_reset_control_tb_top;
  import brc_pkg::*;
  localparam int POWER_UP_TIMER = 50;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  brc_async_s  analog_in;
  brc_cfg_s    cfg;
  brc_evt_s    core_evt;
  logic        device_reset;
  logic        exec_hold;
  logic        brown_out_detector_on;
  logic        bandgap_force_on;
  int          num_errors = 0;
  int          checks_done = 0;
  int          cycles = 0;
  int          n;
  logic [31:0] rd;
  logic        err;
  brc_brownout_reset_control #(.POWER_UP_TIMER_CYCLES(POWER_UP_TIMER)) brc_brownout_reset_control_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .analog_in(analog_in), .cfg(cfg), .core_evt(core_evt),
    .device_reset(device_reset), .exec_hold(exec_hold),
    .brown_out_detector_on(brown_out_detector_on), .bandgap_force_on(bandgap_force_on)
  );
  // ****************************************************************
  // Clock, cycle ceiling and closing report
  // ****************************************************************
  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // Tests need well under a thousand cycles; a hang ends here
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      num_errors++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer; an idle cycle first keeps each strobe to one change per edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rchk
  task automatic wait_run();
    n = 0;
    while (device_reset !== 1'b0)
    begin
      @(posedge pclk);
      n++;
    end
  endtask : wait_run
  task automatic power_on();
    analog_in.por_low <= 1'b1;
    repeat (4) @(posedge pclk);
    analog_in.por_low <= 1'b0;
    wait_run();
  endtask : power_on
  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial
  begin
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 12'h000;
    pwdata    = 32'h0;
    pstrb     = 4'hf;
    analog_in = 6'b100011;
    cfg       = 7'b1100011;
    core_evt  = 6'h00;
    presetn   = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    analog_in.por_low <= 1'b0;
    wait_run();
    chk(n > POWER_UP_TIMER, 1);
    rchk(`BRC_ADDR_CTRL, 32'h81);
    rchk(`BRC_ADDR_PART, {18'h0, `BRC_PART_ID_DEFAULT});
    rchk(`BRC_ADDR_REV, {18'h0, `BRC_REV_ID_DEFAULT});
    apb(1'b1, `BRC_ADDR_REV, 32'h3fff);
    chk(err, 1);
    rchk(`BRC_ADDR_REV, {18'h0, `BRC_REV_ID_DEFAULT});
    apb(1'b0, 12'h00c, 32'h0);
    chk(err, 1);
    chk(rd, 32'h0);
    apb(1'b1, `BRC_ADDR_CTRL, 32'hff);
    rchk(`BRC_ADDR_CTRL, 32'hc1);
    chk(bandgap_force_on, 0);
    $display("test power-up done");
    // A dip shorter than the filter must pass unseen
    analog_in.below_trip_high <= 1'b1;
    repeat (8) @(posedge pclk);
    analog_in.below_trip_high <= 1'b0;
    repeat (30) @(posedge pclk);
    chk(device_reset, 0);
    cfg.brown_out_trip_select <= 1'b1;
    analog_in.below_trip_high <= 1'b1;
    repeat (40) @(posedge pclk);
    chk(device_reset, 0);
    analog_in.below_trip_low <= 1'b1;
    repeat (40) @(posedge pclk);
    chk(device_reset, 1);
    analog_in.below_trip_high <= 1'b0;
    analog_in.below_trip_low <= 1'b0;
    wait_run();
    rchk(`BRC_ADDR_CTRL, 32'h81);
    analog_in.lp_bor_req <= 1'b1;
    repeat (40) @(posedge pclk);
    chk(device_reset, 1);
    analog_in.lp_bor_req <= 1'b0;
    wait_run();
    $display("test brown-out done");
    // Other sources reset but keep the control bits; a core pulse resets one cycle
    apb(1'b1, `BRC_ADDR_CTRL, 32'h40);
    for (int i = 2; i < 6; i++)
    begin
      core_evt[i] <= 1'b1;
      @(posedge pclk);
      core_evt[i] <= 1'b0;
      @(posedge pclk);
      chk(device_reset, 1);
      wait_run();
    end
    analog_in.ext_pin_n <= 1'b0;
    repeat (4) @(posedge pclk);
    chk(device_reset, 1);
    analog_in.ext_pin_n <= 1'b1;
    wait_run();
    rchk(`BRC_ADDR_CTRL, 32'h41);
    // Programming exit behaves as power-on and restores the control bits
    core_evt.prog_exit <= 1'b1;
    @(posedge pclk);
    core_evt.prog_exit <= 1'b0;
    @(posedge pclk);
    chk(device_reset, 1);
    wait_run();
    rchk(`BRC_ADDR_CTRL, 32'h81);
    // Disabled stack and pin sources must not reset
    cfg.stack_reset_enable <= 1'b0;
    cfg.external_reset_enable <= 1'b0;
    core_evt.stack_ovf <= 1'b1;
    analog_in.ext_pin_n <= 1'b0;
    @(posedge pclk);
    core_evt.stack_ovf <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(device_reset, 0);
    analog_in.ext_pin_n <= 1'b1;
    $display("test sources done");
    // Software mode: the enable bit switches the detector, sleep does not
    cfg.brown_out_mode_field <= `BRC_MODE_SOFTWARE;
    power_on();
    chk(brown_out_detector_on, 1);
    apb(1'b1, `BRC_ADDR_CTRL, 32'h40);
    rchk(`BRC_ADDR_CTRL, 32'h40);
    chk({brown_out_detector_on, bandgap_force_on}, 2'b01);
    apb(1'b1, `BRC_ADDR_CTRL, 32'h80);
    core_evt.sleep <= 1'b1;
    repeat (4) @(posedge pclk);
    chk(brown_out_detector_on, 1);
    cfg.brown_out_mode_field <= `BRC_MODE_OFF_SLEEP;
    repeat (4) @(posedge pclk);
    chk(brown_out_detector_on, 0);
    core_evt.sleep <= 1'b0;
    apb(1'b1, `BRC_ADDR_CTRL, 32'h40);
    repeat (2) @(posedge pclk);
    chk({brown_out_detector_on, bandgap_force_on}, 2'b11);
    chk(exec_hold, 0);
    // Awake in mode 10 with the detector not ready: execution is held
    analog_in.det_ready <= 1'b0;
    repeat (4) @(posedge pclk);
    chk(exec_hold, 1);
    analog_in.det_ready <= 1'b1;
    repeat (4) @(posedge pclk);
    chk(exec_hold, 0);
    $display("test modes done");
    // Detector off and timer disabled: release follows power-on at once
    cfg.brown_out_mode_field <= `BRC_MODE_ALWAYS_OFF;
    cfg.power_up_timer_enable_n <= 1'b1;
    power_on();
    chk(n < 12, 1);
    rchk(`BRC_ADDR_CTRL, 32'h80);
    $display("test mode off done");
    stop_test();
  end
endmodule : brc_brownout_reset_control_tb_top
`default_nettype wire

// ---- tb/brc_chk.sv ----
// Port checker for the brown-out reset controller
`timescale 1ns/100ps
`default_nettype none
`include "brc_defines.svh"
module brc_chk #(
  parameter int POWER_UP_TIMER_CYCLES = 50
) (
  input wire logic               pclk,
  input wire logic               presetn,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [11:0]        paddr,
  input wire logic [31:0]        pwdata,
  input wire logic [3:0]         pstrb,
  input wire logic [31:0]        prdata,
  input wire logic               pready,
  input wire logic               pslverr,
  input wire brc_pkg::brc_async_s analog_in,
  input wire brc_pkg::brc_cfg_s   cfg,
  input wire brc_pkg::brc_evt_s   core_evt,
  input wire logic               device_reset,
  input wire logic               exec_hold,
  input wire logic               brown_out_detector_on,
  input wire logic               bandgap_force_on
);
  import brc_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  int since_por;
  // ****************************************************************
  // Supply age: the start-up delay is measured against it
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      since_por <= 0;
    else if (analog_in.por_low)
      since_por <= 0;
    else if (since_por < 100000)
      since_por <= since_por + 1;
  property p_unimpl_zero;
    pready && !pwrite && paddr == `BRC_ADDR_CTRL |-> prdata[31:8] == 0 && prdata[5:1] == 0;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero)
    else $error("control read shows unimplemented bits");
  property p_id_ro;
    pready && pwrite && paddr inside {`BRC_ADDR_PART, `BRC_ADDR_REV} |-> pslverr;
  endproperty
  a_id_ro: assert property (p_id_ro)
    else $error("identity write not refused");
  property p_por_hold;
    analog_in.por_low [*4] |-> device_reset;
  endproperty
  a_por_hold: assert property (p_por_hold)
    else $error("reset dropped while supply low");
  property p_power_up_timer;
    $fell(device_reset) && !cfg.power_up_timer_enable_n |-> since_por > POWER_UP_TIMER_CYCLES;
  endproperty
  a_power_up_timer: assert property (p_power_up_timer)
    else $error("reset released before timer expiry");
  property p_fast_start;
    $fell(analog_in.por_low) && cfg.brown_out_mode_field == `BRC_MODE_ALWAYS_OFF
      && cfg.power_up_timer_enable_n && analog_in.ext_pin_n |-> ##[2:10] !device_reset;
  endproperty
  a_fast_start: assert property (p_fast_start)
    else $error("mode off start-up delayed");
  property p_bandgap;
    $stable(cfg) && cfg.brown_out_mode_field[1] == cfg.brown_out_mode_field[0]
      |-> !bandgap_force_on;
  endproperty
  a_bandgap: assert property (p_bandgap)
    else $error("bandgap forced in mode 11 or 00");
  property p_det_off;
    $stable(cfg) && cfg.brown_out_mode_field == `BRC_MODE_ALWAYS_OFF |-> !brown_out_detector_on;
  endproperty
  a_det_off: assert property (p_det_off)
    else $error("detector on in mode 00");
  property p_wdog;
    $rose(core_evt.watchdog) |-> ##[1:2] device_reset;
  endproperty
  a_wdog: assert property (p_wdog)
    else $error("watchdog did not reset");
  c_release: cover property ($fell(device_reset));
  c_refused: cover property (pready && pslverr);
  c_bandgap: cover property (bandgap_force_on);
endmodule : brc_chk
bind brc_brownout_reset_control brc_chk #(.POWER_UP_TIMER_CYCLES(POWER_UP_TIMER_CYCLES)) brc_chk_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .analog_in(analog_in), .cfg(cfg), .core_evt(core_evt),
  .device_reset(device_reset), .exec_hold(exec_hold),
  .brown_out_detector_on(brown_out_detector_on), .bandgap_force_on(bandgap_force_on)
);
`default_nettype wire
